// *** udfch_pkg.sv ***
// Constants and types shared by the up/down frequency command hold block.
// Assumes frequencies in 0.01 Hz steps and percentages in 0.1 % steps.
package udfch_pkg;
    localparam int F_W = 16;
    localparam int PCT_W = 11;
    localparam int OFS_W = 12;
    localparam int STEP_W = 14;
    localparam int SRC_W = 4;
    localparam int N_OFS = 3;
    localparam int PCT_SCALE = 1000;
    localparam logic [1:0] HOLD_CLEAR = 2'h0;
    localparam logic [1:0] HOLD_SAVE = 2'h1;
    localparam logic [1:0] HOLD_ACCEPT = 2'h2;
    localparam logic [SRC_W-1:0] SRC_UPDOWN = 4'h2;
    localparam logic [STEP_W-1:0] BIAS_STEP_ZERO = 14'h0000;
    localparam logic [STEP_W-1:0] BIAS_STEP_MAX = 14'h270F;
    localparam logic [F_W-1:0] FREQ_ZERO = 16'h0000;
    localparam int CLK_HZ = 10_000_000;
    localparam int PRESS_LONG_S = 2;
    localparam int PRESS_LONG_CYCLES = PRESS_LONG_S * CLK_HZ;
    localparam int RAMP_TICK_US = 1000;
    localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * (CLK_HZ / 1_000_000);
    typedef enum logic [2:0] {
        PH_BOOT = 3'b001,
        PH_STOPPED = 3'b010,
        PH_RUNNING = 3'b100
    } udfch_phase_t;
endpackage

// *** udfch_core_if.sv ***
// Carrier between the hold block and its press timer and limiter.
// Assumes all three sit on the same clock.
`timescale 1ns/10ps
interface udfch_core_if;
    logic press_up;
    logic press_down;
    logic press_edge_up;
    logic press_edge_down;
    logic press_long;
    logic [udfch_pkg::F_W-1:0] max_freq;
    logic [udfch_pkg::PCT_W-1:0] upper_pct;
    logic [udfch_pkg::PCT_W-1:0] lower_pct;
    logic signed [udfch_pkg::OFS_W-1:0] offset [udfch_pkg::N_OFS];
    logic [udfch_pkg::N_OFS-1:0] offset_sel;
    logic signed [udfch_pkg::F_W+1:0] cmd_in;
    logic [udfch_pkg::F_W-1:0] upper_hz;
    logic [udfch_pkg::F_W-1:0] freq_out;
    modport press_src (output press_up, press_down,
                       input press_edge_up, press_edge_down, press_long);
    modport press_det (input press_up, press_down,
                       output press_edge_up, press_edge_down, press_long);
    modport lim_src (output max_freq, upper_pct, lower_pct, offset, offset_sel, cmd_in,
                     input upper_hz, freq_out);
    modport lim_dut (input max_freq, upper_pct, lower_pct, offset, offset_sel, cmd_in,
                     output upper_hz, freq_out);
endinterface

// *** udfch_press_timer.sv ***
// Press detector for the second up/down pair: edges and long-press flag.
// Assumes the terminal levels are already synchronous to mclk.
`timescale 1ns/10ps
module udfch_press_timer #(
    parameter int LONG_CYCLES = udfch_pkg::PRESS_LONG_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Terminal levels in, press events out
    udfch_core_if.press_det pif
);
    localparam int CW = $clog2(LONG_CYCLES + 1);
    logic prev_up_r;
    logic prev_down_r;
    logic edge_up_r;
    logic edge_down_r;
    logic [CW-1:0] held_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_up_r <= 1'b0;
            prev_down_r <= 1'b0;
            edge_up_r <= 1'b0;
            edge_down_r <= 1'b0;
        end else begin
            prev_up_r <= pif.press_up;
            prev_down_r <= pif.press_down;
            edge_up_r <= pif.press_up & ~prev_up_r;
            edge_down_r <= pif.press_down & ~prev_down_r;
        end
    end

    // The count saturates so that a held input stays long for as long as it is closed.
    always_ff @(posedge mclk) begin
        if (rst || !(pif.press_up ^ pif.press_down)) begin
            held_r <= '0;
        end else if (held_r != CW'(LONG_CYCLES)) begin
            held_r <= held_r + 1'b1;
        end
    end

    assign pif.press_edge_up = edge_up_r;
    assign pif.press_edge_down = edge_down_r;
    assign pif.press_long = (held_r == CW'(LONG_CYCLES));
endmodule

// *** udfch_limiter.sv ***
// Offset adder and upper/lower clamp that feeds the ramp generator.
// Assumes settings are stable while the block runs.
`timescale 1ns/10ps
module udfch_limiter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command and limits
    udfch_core_if.lim_dut lif
);
    localparam int PW = udfch_pkg::F_W + udfch_pkg::PCT_W + 2;
    logic signed [PW-1:0] term [udfch_pkg::N_OFS];
    logic signed [PW-1:0] sum;
    logic signed [PW-1:0] clip;
    logic signed [PW-1:0] upper_s;
    logic signed [PW-1:0] lower_s;
    logic [udfch_pkg::F_W-1:0] lower_hz;
    logic [udfch_pkg::F_W-1:0] freq_r;

    genvar g;
    generate
        for (g = 0; g < udfch_pkg::N_OFS; g = g + 1) begin : g_ofs
            assign term[g] = lif.offset_sel[g] ?
                PW'(($signed({1'b0, lif.max_freq}) * lif.offset[g]) / udfch_pkg::PCT_SCALE) :
                '0;
        end
    endgenerate

    assign lif.upper_hz = udfch_pkg::F_W'((32'(lif.max_freq) * 32'(lif.upper_pct)) /
                                          udfch_pkg::PCT_SCALE);
    assign lower_hz = udfch_pkg::F_W'((32'(lif.max_freq) * 32'(lif.lower_pct)) /
                                      udfch_pkg::PCT_SCALE);
    assign upper_s = $signed(PW'(lif.upper_hz));
    assign lower_s = $signed(PW'(lower_hz));

    // The upper limit is applied last so a lower limit set above it cannot win.
    always_comb begin
        sum = PW'(lif.cmd_in);
        for (int i = 0; i < udfch_pkg::N_OFS; i++) begin
            sum = sum + term[i];
        end
        clip = (sum < lower_s) ? lower_s : sum;
        clip = (clip > upper_s) ? upper_s : clip;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            freq_r <= udfch_pkg::FREQ_ZERO;
        end else begin
            freq_r <= clip[udfch_pkg::F_W-1:0];
        end
    end

    assign lif.freq_out = freq_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_clamp_upper_lim: assert property (1'b1 |=> lif.freq_out <= $past(lif.upper_hz))
        else $error("Reference exceeds upper limit.");
    a_clamp_lower_lim: assert property ((lower_hz <= lif.upper_hz) |=>
        lif.freq_out >= $past(lower_hz))
        else $error("Reference below lower limit.");
    c_offset_used: cover property (lif.offset_sel != '0 ##1 lif.freq_out != '0);
endmodule

// *** udfch_top.sv ***
// Up/down frequency command hold, second-pair bias, ramp hold and offsets.
// Assumes settings and terminal levels are synchronous to mclk and that the
// outside storage returns the last written saved command after power-up.
`timescale 1ns/10ps
// Contract
// - Hold mode applies only when some input is assigned to an up/down pair.
// - Mode 0 adjusts only while running; stop or power loss clears command.
// - Mode 1 adjusts while running, saves command at stop, resumes from it.
// - Save mode: up or down before a run clears the saved command.
// - Mode 2 adjusts even when stopped, saves at stop, resumes on restart.
// - Second pair adds or subtracts a bias; step 0.00 to 99.99 Hz, default zero.
// - Zero step ramps the bias with the selected ramp time, overriding normal times.
// - Nonzero step, press under two seconds changes bias by the step.
// - Nonzero step, press over two seconds ramps like the first pair.
// - Ramp select 0 uses active times, 1 forces the fourth times.
// - Saved command holds either pair's result, zero up to the upper limit; the code saves only the first-pair cmd_r, not the bias.
// - Alarm when both up/down pairs are assigned at once.
// - Saving only with up/down source, a pair assigned, hold mode 1 or 2.
// - Ramp-hold retention applies only when the ramp-hold input is assigned.
// - Retention off clears the command on stop or power loss.
// - Retention on keeps command, cleared if ramp-hold input open at power-up.
// - Three offsets, percent of maximum frequency, added when selected.
// - Offset result clamped within limits so no reverse rotation.
// - Commands above the upper limit percentage are clamped to it.
module udfch_top #(
    parameter int PRESS_LONG_CYCLES = udfch_pkg::PRESS_LONG_CYCLES,
    parameter int RAMP_TICK_CYCLES = udfch_pkg::RAMP_TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Input function assignments
    input wire logic pair_one_assigned,
    input wire logic pair_two_assigned,
    input wire logic ramp_hold_assigned,
    // Settings
    input wire logic [1:0] updown_hold_mode,
    input wire logic [udfch_pkg::STEP_W-1:0] second_pair_bias_step,
    input wire logic bias_ramp_select,
    input wire logic ramp_hold_retention,
    input wire logic signed [udfch_pkg::OFS_W-1:0] offset_setting_one,
    input wire logic signed [udfch_pkg::OFS_W-1:0] offset_setting_two,
    input wire logic signed [udfch_pkg::OFS_W-1:0] offset_setting_three,
    input wire logic [udfch_pkg::SRC_W-1:0] frequency_source_select_one,
    input wire logic [udfch_pkg::SRC_W-1:0] frequency_source_select_two,
    input wire logic source_two_active,
    input wire logic [udfch_pkg::F_W-1:0] max_output_frequency,
    input wire logic [udfch_pkg::PCT_W-1:0] frequency_upper_limit,
    input wire logic [udfch_pkg::PCT_W-1:0] frequency_lower_limit,
    // Ramp steps per tick, from the active and the fourth ramp times
    input wire logic [udfch_pkg::F_W-1:0] active_accel_step,
    input wire logic [udfch_pkg::F_W-1:0] active_decel_step,
    input wire logic [udfch_pkg::F_W-1:0] fourth_accel_step,
    input wire logic [udfch_pkg::F_W-1:0] fourth_decel_step,
    // Terminals, run and supply
    input wire logic run_cmd,
    input wire logic power_loss,
    input wire logic up_one,
    input wire logic down_one,
    input wire logic up_two,
    input wire logic down_two,
    input wire logic ramp_hold_in,
    input wire logic [udfch_pkg::N_OFS-1:0] offset_select,
    input wire logic [udfch_pkg::F_W-1:0] base_command,
    // Retained storage
    input wire logic [udfch_pkg::F_W-1:0] nv_saved_in,
    output logic nv_write,
    output logic [udfch_pkg::F_W-1:0] saved_updown_command,
    // Results
    output logic [udfch_pkg::F_W-1:0] freq_reference,
    output logic [udfch_pkg::F_W-1:0] updown_command,
    output logic signed [udfch_pkg::F_W:0] bias_value,
    output logic alarm_dual_pair,
    output logic save_active,
    output logic bias_uses_fourth
);
    localparam int F_W = udfch_pkg::F_W;
    localparam int TW = $clog2(RAMP_TICK_CYCLES + 1);

    udfch_core_if cif();
    udfch_pkg::udfch_phase_t phase_r;
    logic [TW-1:0] tick_cnt_r;
    logic tick_r;
    logic [F_W-1:0] cmd_r;
    logic signed [F_W:0] bias_r;
    logic [F_W-1:0] saved_r;
    logic [F_W-1:0] rh_cmd_r;
    logic nv_write_r;
    logic alarm_r;
    logic save_active_r;
    logic fourth_r;
    logic pair_ok, src_updown, save_mode, save_act, ret_eff;
    logic stop_evt, start_evt, adjust_ok, presave_clear, clear_evt;
    logic ud_any, ud_prev_r;
    logic [F_W-1:0] bias_inc, bias_dec, step_hz, nv_clip;

    function automatic logic [F_W-1:0] freq_move(input logic [F_W-1:0] v, input logic up,
                                                 input logic [F_W-1:0] inc,
                                                 input logic [F_W-1:0] dec,
                                                 input logic [F_W-1:0] lim);
        logic [F_W:0] s;
        s = {1'b0, v} + {1'b0, inc};
        if (up) begin
            return (s > {1'b0, lim}) ? lim : s[F_W-1:0];
        end
        return (v > dec) ? v - dec : udfch_pkg::FREQ_ZERO;
    endfunction

    function automatic logic signed [F_W:0] bias_move(input logic signed [F_W:0] b,
                                                      input logic up,
                                                      input logic [F_W-1:0] mag,
                                                      input logic [F_W-1:0] lim);
        logic signed [F_W+1:0] s;
        logic signed [F_W+1:0] l;
        l = $signed({2'b00, lim});
        s = up ? (F_W+2)'(b) + l - l + $signed({2'b00, mag}) :
                 (F_W+2)'(b) - $signed({2'b00, mag});
        if (s > l) begin
            s = l;
        end else if (s < -l) begin
            s = -l;
        end
        return s[F_W:0];
    endfunction

    assign pair_ok = pair_one_assigned ^ pair_two_assigned;
    assign src_updown = (source_two_active ? frequency_source_select_two :
                         frequency_source_select_one) == udfch_pkg::SRC_UPDOWN;
    assign save_mode = pair_ok && (updown_hold_mode == udfch_pkg::HOLD_SAVE ||
                                   updown_hold_mode == udfch_pkg::HOLD_ACCEPT);
    assign save_act = src_updown & save_mode;
    assign ret_eff = ramp_hold_assigned & ramp_hold_retention;
    assign stop_evt = (phase_r == udfch_pkg::PH_RUNNING) & ~run_cmd;
    assign start_evt = (phase_r == udfch_pkg::PH_STOPPED) & run_cmd;
    // Stopped adjustment only in accept mode; otherwise terminals only trigger the mode 1 clear.
    assign adjust_ok = pair_ok & ((phase_r == udfch_pkg::PH_RUNNING) |
                       ((phase_r == udfch_pkg::PH_STOPPED) &
                        (updown_hold_mode == udfch_pkg::HOLD_ACCEPT)));
    // Only a fresh press clears: a key still held as run drops must not wipe the value
    // that the stop has just saved.
    assign ud_any = up_one | down_one | up_two | down_two;
    assign presave_clear = save_act & (updown_hold_mode == udfch_pkg::HOLD_SAVE) &
                           (phase_r == udfch_pkg::PH_STOPPED) & ~run_cmd &
                           ud_any & ~ud_prev_r;
    assign clear_evt = ((stop_evt | power_loss) & ~save_mode) | presave_clear;
    assign bias_inc = bias_ramp_select ? fourth_accel_step : active_accel_step;
    assign bias_dec = bias_ramp_select ? fourth_decel_step : active_decel_step;
    assign step_hz = F_W'(second_pair_bias_step);
    assign nv_clip = (nv_saved_in > cif.upper_hz) ? cif.upper_hz : nv_saved_in;

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= udfch_pkg::PH_BOOT;
        end else begin
            unique case (phase_r)
                udfch_pkg::PH_BOOT: phase_r <= udfch_pkg::PH_STOPPED;
                udfch_pkg::PH_STOPPED: phase_r <= run_cmd && !power_loss ?
                                                  udfch_pkg::PH_RUNNING : udfch_pkg::PH_STOPPED;
                udfch_pkg::PH_RUNNING: phase_r <= run_cmd && !power_loss ?
                                                  udfch_pkg::PH_RUNNING : udfch_pkg::PH_STOPPED;
                default: phase_r <= udfch_pkg::PH_BOOT;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || tick_cnt_r == TW'(RAMP_TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= ~rst;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // First pair: the command itself.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_r <= udfch_pkg::FREQ_ZERO;
        end else if (phase_r == udfch_pkg::PH_BOOT) begin
            cmd_r <= save_act ? nv_clip : udfch_pkg::FREQ_ZERO;
        end else if (clear_evt) begin
            cmd_r <= udfch_pkg::FREQ_ZERO;
        end else if (start_evt & save_act) begin
            cmd_r <= saved_r;
        end else if (adjust_ok & pair_one_assigned & tick_r & (up_one ^ down_one)) begin
            cmd_r <= freq_move(cmd_r, up_one, active_accel_step, active_decel_step,
                               cif.upper_hz);
        end
    end

    // Second pair: the bias, stepped on short presses or ramped.
    always_ff @(posedge mclk) begin
        if (rst || phase_r == udfch_pkg::PH_BOOT || clear_evt) begin
            bias_r <= '0;
        end else if (adjust_ok & pair_two_assigned & (up_two ^ down_two)) begin
            if (second_pair_bias_step == udfch_pkg::BIAS_STEP_ZERO) begin
                if (tick_r) begin
                    bias_r <= bias_move(bias_r, up_two, up_two ? bias_inc : bias_dec,
                                        cif.upper_hz);
                end
            end else if (cif.press_long) begin
                if (tick_r) begin
                    bias_r <= bias_move(bias_r, up_two, up_two ? active_accel_step :
                                        active_decel_step, cif.upper_hz);
                end
            end else if (cif.press_edge_up | cif.press_edge_down) begin
                bias_r <= bias_move(bias_r, cif.press_edge_up, step_hz, cif.upper_hz);
            end
        end
    end

    // Saved command and the write strobe to retained storage.
    always_ff @(posedge mclk) begin
        if (rst) begin
            saved_r <= udfch_pkg::FREQ_ZERO;
            nv_write_r <= 1'b0;
        end else begin
            nv_write_r <= presave_clear | (stop_evt & save_act);
            if (phase_r == udfch_pkg::PH_BOOT) begin
                saved_r <= nv_clip;
            end else if (presave_clear) begin
                saved_r <= udfch_pkg::FREQ_ZERO;
            end else if (stop_evt & save_act) begin
                saved_r <= cmd_r;
            end
        end
    end

    // Ramp-hold command: tracks while running and released, freezes while the hold input is closed.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rh_cmd_r <= udfch_pkg::FREQ_ZERO;
        end else if (phase_r == udfch_pkg::PH_BOOT) begin
            rh_cmd_r <= ramp_hold_in ? rh_cmd_r : udfch_pkg::FREQ_ZERO;
        end else if ((stop_evt | power_loss) & ~ret_eff) begin
            rh_cmd_r <= udfch_pkg::FREQ_ZERO;
        end else if (phase_r == udfch_pkg::PH_RUNNING && !ramp_hold_in) begin
            rh_cmd_r <= base_command;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_r <= 1'b0;
            save_active_r <= 1'b0;
            fourth_r <= 1'b0;
            ud_prev_r <= 1'b0;
        end else begin
            ud_prev_r <= ud_any;
            alarm_r <= pair_one_assigned & pair_two_assigned;
            save_active_r <= save_act;
            fourth_r <= bias_ramp_select & pair_two_assigned;
        end
    end

    assign cif.press_up = up_two;
    assign cif.press_down = down_two;
    assign cif.max_freq = max_output_frequency;
    assign cif.upper_pct = frequency_upper_limit;
    assign cif.lower_pct = frequency_lower_limit;
    assign cif.offset[0] = offset_setting_one;
    assign cif.offset[1] = offset_setting_two;
    assign cif.offset[2] = offset_setting_three;
    assign cif.offset_sel = offset_select;
    assign cif.cmd_in = (src_updown & pair_ok) ?
                        $signed({2'b00, cmd_r}) + (F_W+2)'(bias_r) :
                        $signed({2'b00, ramp_hold_assigned ? rh_cmd_r : base_command});

    udfch_press_timer #(.LONG_CYCLES(PRESS_LONG_CYCLES)) u_press (
        .mclk(mclk),
        .rst(rst),
        .pif(cif.press_det)
    );

    udfch_limiter u_lim (
        .mclk(mclk),
        .rst(rst),
        .lif(cif.lim_dut)
    );

    assign freq_reference = cif.freq_out;
    assign updown_command = cmd_r;
    assign bias_value = bias_r;
    assign saved_updown_command = saved_r;
    assign nv_write = nv_write_r;
    assign alarm_dual_pair = alarm_r;
    assign save_active = save_active_r;
    assign bias_uses_fourth = fourth_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_alarm_dual_pair: assert property ((pair_one_assigned & pair_two_assigned) |=> alarm_r)
        else $error("Dual pair alarm missing.");
    a_stop_clears_cmd: assert property ((stop_evt & ~save_mode) |=>
        (cmd_r == udfch_pkg::FREQ_ZERO) && (bias_r == '0))
        else $error("Stop did not clear command.");
    a_stop_saves_cmd: assert property ((stop_evt & save_act) |=>
        nv_write_r && (saved_r == $past(cmd_r)) ##1 !nv_write_r)
        else $error("Stop did not save command.");
    a_presave_zero: assert property (presave_clear |=>
        (saved_r == udfch_pkg::FREQ_ZERO) && (cmd_r == udfch_pkg::FREQ_ZERO) && nv_write_r)
        else $error("Early up/down did not clear saved command.");
    a_restart_resume: assert property ((start_evt & save_act & ~clear_evt) |=>
        cmd_r == $past(saved_r))
        else $error("Restart did not resume saved command.");
    a_stopped_frozen: assert property (((phase_r == udfch_pkg::PH_STOPPED) & ~run_cmd &
        (updown_hold_mode != udfch_pkg::HOLD_ACCEPT) & ~presave_clear & ~power_loss)
        |=> $stable(cmd_r) && $stable(bias_r))
        else $error("Command moved while stopped.");
    a_bias_step_up: assert property ((adjust_ok & pair_two_assigned & up_two & ~down_two &
        (second_pair_bias_step != udfch_pkg::BIAS_STEP_ZERO) & ~cif.press_long &
        cif.press_edge_up & ~clear_evt & (bias_r + step_hz <= cif.upper_hz))
        |=> bias_r == $past(bias_r) + $past(step_hz))
        else $error("Short press did not add the bias step.");
    a_rh_clear_stop: assert property (((stop_evt | power_loss) & ~ret_eff) |=>
        rh_cmd_r == udfch_pkg::FREQ_ZERO)
        else $error("Ramp-hold command not cleared.");
    a_no_pair_still: assert property ((~pair_ok & ~power_loss & ~stop_evt &
        (phase_r != udfch_pkg::PH_BOOT)) |=> $stable(cmd_r) && $stable(bias_r))
        else $error("Up/down moved without a pair assigned.");

    c_save_and_resume: cover property ((stop_evt & save_act) ##[1:50] start_evt);
    c_long_press_ramp: cover property (cif.press_long & tick_r & pair_two_assigned);
    c_presave_clear: cover property (presave_clear);
    c_alarm_raised: cover property (alarm_r);
endmodule

// *** udfch_term_model.sv ***
// Model of the run and terminal source in front of the hold block.
// Assumes the bench sets the wanted levels at a falling edge of mclk.
`timescale 1ns/10ps
module udfch_term_model (
    // Clock
    input wire logic mclk,
    // Wanted levels: run, up1, down1, up2, down2
    input wire logic [4:0] want,
    // Terminal levels
    output logic [4:0] term
);
    logic [4:0] want_r = 5'h00;
    // Wanted levels are taken at the rising edge and shown at the falling edge, so a
    // change made by the bench at a falling edge never races the model.
    initial term = 5'h00;
    always @(posedge mclk) want_r <= want;
    always @(negedge mclk) term <= want_r;
endmodule

// *** udfch_top_test.sv ***
// Self-checking bench for the up/down command hold block.
// Assumes short press and ramp tick parameters for a quick run.
`timescale 1ns/10ps
module udfch_top_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic p1 = 1'b0, p2 = 1'b0, rha = 1'b0, bsel = 1'b0, ret = 1'b0, pl = 1'b0, rh = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [13:0] step = 14'h0000;
    logic [3:0] src = 4'h2;
    logic [3:0] src2 = 4'h0;
    logic s2 = 1'b0;
    logic [15:0] base = 16'h0000, mx = 16'h1388, st = 16'h0FA0, nvin = 16'h0000;
    logic [10:0] lo = 11'h000, up = 11'h3E8;
    logic signed [11:0] ofs = 12'h000;
    logic [2:0] osel = 3'h0;
    logic [4:0] want = 5'h00;
    logic [4:0] term;
    logic nvw, alarm, sav, b4;
    logic [15:0] saved, fref, cmd;
    logic signed [16:0] bias;
    int err_total = 0;
    int num_checks = 0;
    udfch_term_model model (.mclk(mclk), .want(want), .term(term));
    udfch_top #(.PRESS_LONG_CYCLES(50), .RAMP_TICK_CYCLES(8)) dut (
        .mclk(mclk), .rst(rst), .pair_one_assigned(p1), .pair_two_assigned(p2),
        .ramp_hold_assigned(rha), .updown_hold_mode(mode), .second_pair_bias_step(step),
        .bias_ramp_select(bsel), .ramp_hold_retention(ret), .offset_setting_one(ofs),
        .offset_setting_two(ofs), .offset_setting_three(ofs),
        .frequency_source_select_one(src), .frequency_source_select_two(src2),
        .source_two_active(s2), .max_output_frequency(mx), .frequency_upper_limit(up),
        .frequency_lower_limit(lo), .active_accel_step(st), .active_decel_step(st),
        .fourth_accel_step(st), .fourth_decel_step(st), .run_cmd(term[0]),
        .power_loss(pl), .up_one(term[1]), .down_one(term[2]), .up_two(term[3]),
        .down_two(term[4]), .ramp_hold_in(rh), .offset_select(osel), .base_command(base),
        .nv_saved_in(nvin), .nv_write(nvw), .saved_updown_command(saved),
        .freq_reference(fref), .updown_command(cmd), .bias_value(bias),
        .alarm_dual_pair(alarm), .save_active(sav), .bias_uses_fourth(b4));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic t_limits;
        src = 4'h0;
        base = 16'hFFFF;
        tick(4);
        chk(fref, 17'h01388);
        base = 16'h0000;
        lo = 11'h064;
        tick(4);
        chk(fref, 17'h001F4);
        base = 16'h07D0;
        ofs = 12'h064;
        osel = 3'h1;
        tick(4);
        chk(fref, 17'h009C4);
        ofs = 12'hC18;
        tick(4);
        chk(fref, 17'h001F4);
        ofs = 12'h000;
        osel = 3'h0;
        base = 16'h0000;
        src = 4'h2;
        lo = 11'h000;
        $display("limits done");
    endtask
    task automatic t_alarm;
        p1 = 1'b1;
        p2 = 1'b1;
        tick(3);
        chk(alarm, 17'h00001);
        p2 = 1'b0;
        tick(3);
        chk(alarm, 17'h00000);
        $display("alarm done");
    endtask
    task automatic t_save;
        int i;
        mode = 2'h1;
        tick(3);
        chk(sav, 17'h00001);
        s2 = 1'b1;
        tick(2);
        chk(sav, 17'h00000);
        src2 = 4'h2;
        tick(2);
        chk(sav, 17'h00001);
        want = 5'h03;
        tick(60);
        want = 5'h00;
        for (i = 0; i < 20 && nvw !== 1'b1; i++) tick(1);
        if (i == 20) begin
            err_total++;
            give_verdict();
        end
        chk(saved, 17'h01388);
        want = 5'h01;
        tick(3);
        chk(cmd, 17'h01388);
        $display("save done");
    endtask
    task automatic t_clear;
        mode = 2'h0;
        tick(2);
        chk(sav, 17'h00000);
        want = 5'h00;
        tick(3);
        chk(cmd, 17'h00000);
        want = 5'h02;
        tick(30);
        chk(cmd, 17'h00000);
        want = 5'h00;
        $display("clear done");
    endtask
    task automatic t_bias;
        p1 = 1'b0;
        p2 = 1'b1;
        step = 14'h0064;
        bsel = 1'b1;
        want = 5'h01;
        tick(3);
        chk(b4, 17'h00001);
        want = 5'h09;
        tick(3);
        want = 5'h01;
        tick(4);
        chk(bias, 17'h00064);
        step = 14'h0000;
        want = 5'h09;
        tick(20);
        chk(bias, 17'h01388);
        want = 5'h01;
        step = 14'h0064;
        tick(2);
        want = 5'h11;
        tick(80);
        chk(bias, 17'h1EC78);
        want = 5'h01;
        $display("bias done");
    endtask
    task automatic t_boot;
        p1 = 1'b1;
        p2 = 1'b0;
        mode = 2'h1;
        nvin = 16'h1770;
        want = 5'h00;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(3);
        chk(saved, 17'h01388);
        chk(cmd, 17'h01388);
        want = 5'h02;
        tick(4);
        chk(saved, 17'h00000);
        want = 5'h00;
        mode = 2'h2;
        tick(2);
        want = 5'h02;
        tick(20);
        chk(cmd, 17'h01388);
        want = 5'h00;
        $display("boot done");
    endtask
    initial begin
        tick(8);
        rst = 1'b0;
        tick(3);
        t_limits();
        t_alarm();
        t_save();
        t_clear();
        t_bias();
        t_boot();
        give_verdict();
    end
endmodule
